// ===== hdl/cod_decode_top.sv
// Opcode decode and sequencing for an 8-bit accumulator core.
// Assumes opcode and operand bytes arrive from program memory on clk_sys.
`timescale 1ns/1ns
`default_nettype none
module cod_decode_top (
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                op_valid,
  input  wire logic [7:0]          op_byte,
  input  wire logic                operand_valid,
  input  wire logic [7:0]          operand_byte,
  input  wire logic [7:0]          index_val,
  input  wire logic [4:0]          ccr_in,
  input  wire logic                irq_pin,
  output logic                     op_ready,
  output logic                     fetch_req,
  output logic                     busy,
  output cod_pkg::cod_class_t      dec_class,
  output cod_pkg::cod_mode_t       dec_mode,
  output logic [1:0]               dec_length,
  output logic [3:0]               dec_row,
  output logic [2:0]               dec_bit_num,
  output logic                     dec_bit_when_set,
  output logic                     dec_undefined,
  output logic [15:0]              operand_word,
  output logic                     acc_we,
  output logic [7:0]               acc_value,
  output logic                     ccr_we,
  output logic [4:0]               ccr_out,
  output logic                     clk_halt,
  output logic                     insn_done
);
  import cod_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC, ST_HALT} cod_state_t;

  cod_dec_if  ifc ();
  cod_state_t st;
  cod_state_t next_st;
  logic [7:0] opc;
  logic [7:0] next_opc;
  logic [1:0] remain;
  logic [1:0] next_remain;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic       irq_s1;
  logic       irq_s2;
  logic       irq_s3;
  logic       irq_level;
  logic       next_irq_level;

  logic              next_op_ready;
  logic              next_fetch_req;
  logic              next_busy;
  cod_class_t        next_dec_class;
  cod_mode_t         next_dec_mode;
  logic [1:0]        next_dec_length;
  logic [3:0]        next_dec_row;
  logic [2:0]        next_dec_bit_num;
  logic              next_dec_bit_when_set;
  logic              next_dec_undefined;
  logic [15:0]       next_operand_word;
  logic              next_acc_we;
  logic [7:0]        next_acc_value;
  logic              next_ccr_we;
  logic [4:0]        next_ccr_out;
  logic              next_clk_halt;
  logic              next_insn_done;

  // ===========================================================
  // Opcode lookup
  // ===========================================================
  assign ifc.opcode = (st == ST_IDLE) ? op_byte : opc;

  cod_opcode_lut u_lut (
    .ifc (ifc.lut)
  );

  // ===========================================================
  // Interrupt pin synchroniser
  // ===========================================================
  always_comb begin
    next_irq_level = irq_level;
    if (irq_s2 == irq_s3) begin
      next_irq_level = irq_s3;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_s1    <= 1'b0;
      irq_s2    <= 1'b0;
      irq_s3    <= 1'b0;
      irq_level <= 1'b0;
    end else begin
      irq_s1    <= irq_pin;
      irq_s2    <= irq_s1;
      irq_s3    <= irq_s2;
      irq_level <= next_irq_level;
    end
  end

  // ===========================================================
  // Sequencer
  // ===========================================================
  always_comb begin
    next_st               = st;
    next_opc              = opc;
    next_remain           = remain;
    next_cnt              = cnt;
    next_dec_class        = dec_class;
    next_dec_mode         = dec_mode;
    next_dec_length       = dec_length;
    next_dec_row          = dec_row;
    next_dec_bit_num      = dec_bit_num;
    next_dec_bit_when_set = dec_bit_when_set;
    next_dec_undefined    = dec_undefined;
    next_operand_word     = operand_word;
    next_acc_we           = 1'b0;
    next_acc_value        = acc_value;
    next_ccr_we           = 1'b0;
    next_ccr_out          = ccr_out;
    next_clk_halt         = clk_halt;
    next_insn_done        = 1'b0;
    case (st)
      ST_IDLE: begin
        if (op_valid) begin
          next_opc              = op_byte;
          next_cnt              = ifc.cycles - 4'h2;
          next_remain           = ifc.length - 2'h1;
          next_dec_class        = ifc.iclass;
          next_dec_mode         = ifc.mode;
          next_dec_length       = ifc.length;
          next_dec_row          = ifc.row;
          next_dec_bit_num      = ifc.bit_num;
          next_dec_bit_when_set = ifc.bit_when_set;
          next_dec_undefined    = ~ifc.defined;
          next_operand_word     = 16'h0000;
          next_st               = (ifc.length == LEN_ONE) ? ST_EXEC : ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (operand_valid) begin
          next_operand_word = {operand_word[7:0], operand_byte};
          next_remain       = remain - 2'h1;
          if (remain == 2'h1) begin
            next_st = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        if (cnt == 4'h0) begin
          next_ccr_we  = 1'b1;
          next_ccr_out = ccr_in;
          case (opc)
            OPC_WAIT, OPC_STOP: next_ccr_out = ccr_in & ~CC_I_MASK;
            OPC_MASK_CLR:       next_ccr_out = ccr_in & ~CC_I_MASK;
            OPC_MASK_SET:       next_ccr_out = ccr_in | CC_I_MASK;
            OPC_CARRY_CLR:      next_ccr_out = ccr_in & ~CC_C_MASK;
            OPC_CARRY_SET:      next_ccr_out = ccr_in | CC_C_MASK;
            default:            next_ccr_out = ccr_in;
          endcase
          if (opc == OPC_IDX_TO_ACC) begin
            next_acc_we    = 1'b1;
            next_acc_value = index_val;
          end
          if (opc == OPC_WAIT || opc == OPC_STOP) begin
            next_clk_halt = 1'b1;
            next_st       = ST_HALT;
          end else begin
            next_insn_done = 1'b1;
            next_st        = ST_IDLE;
          end
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      ST_HALT: begin
        if (irq_level) begin
          next_clk_halt  = 1'b0;
          next_insn_done = 1'b1;
          next_st        = ST_IDLE;
        end
      end
      default: begin
        next_st = ST_IDLE;
      end
    endcase
    next_op_ready  = (next_st == ST_IDLE);
    next_busy      = (next_st != ST_IDLE);
    next_fetch_req = (next_st == ST_FETCH);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st               <= ST_IDLE;
      opc              <= OPC_NOP;
      remain           <= 2'h0;
      cnt              <= 4'h0;
      op_ready         <= 1'b1;
      fetch_req        <= 1'b0;
      busy             <= 1'b0;
      dec_class        <= CLS_CTL;
      dec_mode         <= MODE_INH;
      dec_length       <= LEN_ONE;
      dec_row          <= 4'h0;
      dec_bit_num      <= 3'h0;
      dec_bit_when_set <= 1'b0;
      dec_undefined    <= 1'b0;
      operand_word     <= 16'h0000;
      acc_we           <= 1'b0;
      acc_value        <= 8'h00;
      ccr_we           <= 1'b0;
      ccr_out          <= 5'h00;
      clk_halt         <= 1'b0;
      insn_done        <= 1'b0;
    end else begin
      st               <= next_st;
      opc              <= next_opc;
      remain           <= next_remain;
      cnt              <= next_cnt;
      op_ready         <= next_op_ready;
      fetch_req        <= next_fetch_req;
      busy             <= next_busy;
      dec_class        <= next_dec_class;
      dec_mode         <= next_dec_mode;
      dec_length       <= next_dec_length;
      dec_row          <= next_dec_row;
      dec_bit_num      <= next_dec_bit_num;
      dec_bit_when_set <= next_dec_bit_when_set;
      dec_undefined    <= next_dec_undefined;
      operand_word     <= next_operand_word;
      acc_we           <= next_acc_we;
      acc_value        <= next_acc_value;
      ccr_we           <= next_ccr_we;
      ccr_out          <= next_ccr_out;
      clk_halt         <= next_clk_halt;
      insn_done        <= next_insn_done;
    end
  end

  // ===========================================================
  // Checks
  // ===========================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_take(logic [7:0] code);
    st == ST_IDLE && op_valid && op_byte == code;
  endsequence

  sequence s_idx_done;
    acc_we && insn_done && ccr_we;
  endsequence

  chk_idx_to_acc: assert property (
    s_take(OPC_IDX_TO_ACC) |-> !acc_we ##2 (s_idx_done and
      (acc_value == $past(index_val)) and (ccr_out == $past(ccr_in))))
    else $error("index to accumulator move wrong value, flags or timing");

  chk_wait_mask: assert property (
    s_take(OPC_WAIT) |-> ##2 (clk_halt && ccr_we && !ccr_out[CC_I] &&
      ((ccr_out ^ $past(ccr_in)) & ~CC_I_MASK) == 5'h00))
    else $error("wait did not halt or disturbed other flags");

  chk_halt_holds: assert property (
    clk_halt && !irq_level |=> clk_halt && !insn_done)
    else $error("clock halt released without interrupt");

  chk_column_class: assert property (
    st == ST_IDLE && op_valid && ifc.defined && op_byte[7:4] >= COL_IMM
      |=> dec_class == CLS_REGMEM)
    else $error("register memory column not classed");

  chk_bit_branch: assert property (
    st == ST_IDLE && op_valid && op_byte[7:4] == COL_BIT_BRANCH |=>
      dec_bit_num == $past(op_byte[3:1]) && dec_bit_when_set == !$past(op_byte[0])
      && dec_length == LEN_THREE)
    else $error("bit test and branch decoded wrongly");

  chk_multiply_time: assert property (
    s_take(OPC_MULTIPLY) |-> ##3 (!insn_done)[*8] ##1 insn_done)
    else $error("multiply did not take eleven cycles");

  chk_len_fetch: assert property (
    st == ST_IDLE && op_valid && ifc.length == LEN_THREE |=> fetch_req ##0 remain == 2'h2)
    else $error("three byte instruction not fetching two operands");

  chk_operand_order: assert property (
    st == ST_FETCH && operand_valid |=> operand_word[7:0] == $past(operand_byte)
      && operand_word[15:8] == $past(operand_word[7:0]))
    else $error("operand bytes not assembled high byte first");

  chk_regmem_time: assert property (
    ifc.iclass == CLS_REGMEM && ifc.mode == MODE_IX2 |-> ifc.cycles == CYC_IX2)
    else $error("register memory timing wrong");

  chk_blank_nop: assert property (
    s_take(8'h31) |=> dec_undefined && dec_length == LEN_ONE
      ##1 insn_done && !acc_we)
    else $error("blank opcode not run as no-operation");

endmodule // cod_decode_top
`default_nettype wire

// ===== hdl/cod_pkg.sv
// Constants and types shared by the opcode decoder files.
// Assumes an 8-bit accumulator core clocked by clk_sys.
package cod_pkg;

  // ===========================================================
  // Opcode byte and condition code layout
  // ===========================================================
  localparam int         OP_W       = 8;
  localparam int         CC_W       = 5;
  localparam int         CC_H       = 4;
  localparam int         CC_I       = 3;
  localparam int         CC_N       = 2;
  localparam int         CC_Z       = 1;
  localparam int         CC_C       = 0;
  localparam logic [4:0] CC_I_MASK  = 5'h08;
  localparam logic [4:0] CC_C_MASK  = 5'h01;

  // ===========================================================
  // Columns (upper nibble)
  // ===========================================================
  localparam logic [3:0] COL_BIT_BRANCH = 4'h0;
  localparam logic [3:0] COL_BIT_CHANGE = 4'h1;
  localparam logic [3:0] COL_BRANCH     = 4'h2;
  localparam logic [3:0] COL_RMW_DIR    = 4'h3;
  localparam logic [3:0] COL_RMW_ACC    = 4'h4;
  localparam logic [3:0] COL_RMW_IDX    = 4'h5;
  localparam logic [3:0] COL_RMW_IX1    = 4'h6;
  localparam logic [3:0] COL_RMW_IX     = 4'h7;
  localparam logic [3:0] COL_CTL_LO     = 4'h8;
  localparam logic [3:0] COL_CTL_HI     = 4'h9;
  localparam logic [3:0] COL_IMM        = 4'hA;
  localparam logic [3:0] COL_DIR        = 4'hB;
  localparam logic [3:0] COL_EXT        = 4'hC;
  localparam logic [3:0] COL_IX2        = 4'hD;
  localparam logic [3:0] COL_IX1        = 4'hE;
  localparam logic [3:0] COL_IX         = 4'hF;

  // Populated rows per column family, one bit per row
  localparam logic [15:0] ROWS_RMW    = 16'hB7D9;
  localparam logic [15:0] ROWS_CTL_LO = 16'hC00B;
  localparam logic [15:0] ROWS_CTL_HI = 16'hBF80;
  localparam logic [15:0] ROWS_IMM    = 16'h4F7F;

  // ===========================================================
  // Individual opcodes
  // ===========================================================
  localparam logic [7:0] OPC_INT_RETURN  = 8'h80;
  localparam logic [7:0] OPC_SUB_RETURN  = 8'h81;
  localparam logic [7:0] OPC_SOFT_TRAP   = 8'h83;
  localparam logic [7:0] OPC_STOP        = 8'h8E;
  localparam logic [7:0] OPC_WAIT        = 8'h8F;
  localparam logic [7:0] OPC_ACC_TO_IDX  = 8'h97;
  localparam logic [7:0] OPC_CARRY_CLR   = 8'h98;
  localparam logic [7:0] OPC_CARRY_SET   = 8'h99;
  localparam logic [7:0] OPC_MASK_CLR    = 8'h9A;
  localparam logic [7:0] OPC_MASK_SET    = 8'h9B;
  localparam logic [7:0] OPC_STACK_INIT  = 8'h9C;
  localparam logic [7:0] OPC_NOP         = 8'h9D;
  localparam logic [7:0] OPC_IDX_TO_ACC  = 8'h9F;
  localparam logic [7:0] OPC_MULTIPLY    = 8'h42;

  // ===========================================================
  // Lengths in bytes and cycle counts
  // ===========================================================
  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  localparam logic [3:0] CYC_INH       = 4'h2;
  localparam logic [3:0] CYC_BIT       = 4'h5;
  localparam logic [3:0] CYC_BRANCH    = 4'h3;
  localparam logic [3:0] CYC_RMW_DIR   = 4'h5;
  localparam logic [3:0] CYC_RMW_INH   = 4'h3;
  localparam logic [3:0] CYC_RMW_IX1   = 4'h6;
  localparam logic [3:0] CYC_RMW_IX    = 4'h5;
  localparam logic [3:0] CYC_MULTIPLY  = 4'hB;
  localparam logic [3:0] CYC_SUB_RET   = 4'h6;
  localparam logic [3:0] CYC_INT_RET   = 4'h9;
  localparam logic [3:0] CYC_SOFT_TRAP = 4'hA;
  localparam logic [3:0] CYC_IMM       = 4'h2;
  localparam logic [3:0] CYC_DIR       = 4'h3;
  localparam logic [3:0] CYC_EXT       = 4'h4;
  localparam logic [3:0] CYC_IX2       = 4'h5;
  localparam logic [3:0] CYC_IX1       = 4'h4;
  localparam logic [3:0] CYC_IX        = 4'h3;

  typedef enum logic [2:0] {
    MODE_INH, MODE_IMM, MODE_DIR, MODE_EXT, MODE_IX2, MODE_IX1, MODE_IX, MODE_REL
  } cod_mode_t;

  typedef enum logic [2:0] {
    CLS_BITMAN, CLS_BRANCH, CLS_RMW, CLS_CTL, CLS_REGMEM
  } cod_class_t;

endpackage

// ===== hdl/cod_dec_if.sv
// Interface between the decode sequencer and the opcode lookup.
// Assumes both ends sit in the same clk_sys domain.
`timescale 1ns/1ns
`default_nettype none
interface cod_dec_if;
  import cod_pkg::*;
  logic [7:0]  opcode;
  cod_class_t  iclass;
  cod_mode_t   mode;
  logic [1:0]  length;
  logic [3:0]  cycles;
  logic [3:0]  row;
  logic [2:0]  bit_num;
  logic        bit_when_set;
  logic        defined;

  modport lut  (input opcode, output iclass, mode, length, cycles, row, bit_num,
                bit_when_set, defined);
  modport core (output opcode, input iclass, mode, length, cycles, row, bit_num,
                bit_when_set, defined);
endinterface
`default_nettype wire

// ===== hdl/cod_opcode_lut.sv
// Combinational opcode lookup: class, mode, length, cycles.
// Assumes the opcode on the interface is stable for the cycle it is used.
`timescale 1ns/1ns
`default_nettype none
module cod_opcode_lut (
  cod_dec_if.lut ifc
);
  import cod_pkg::*;

  logic [3:0] col;
  logic [3:0] row;
  assign col = ifc.opcode[7:4];
  assign row = ifc.opcode[3:0];

  // ===========================================================
  // Column and row decode
  // ===========================================================
  always_comb begin
    ifc.iclass       = CLS_CTL;
    ifc.mode         = MODE_INH;
    ifc.length       = LEN_ONE;
    ifc.cycles       = CYC_INH;
    ifc.row          = row;
    ifc.bit_num      = row[3:1];
    ifc.bit_when_set = ~row[0];
    ifc.defined      = 1'b1;
    case (col)
      COL_BIT_BRANCH: begin
        ifc.iclass = CLS_BITMAN;
        ifc.mode   = MODE_DIR;
        ifc.length = LEN_THREE;
        ifc.cycles = CYC_BIT;
      end
      COL_BIT_CHANGE: begin
        ifc.iclass = CLS_BITMAN;
        ifc.mode   = MODE_DIR;
        ifc.length = LEN_TWO;
        ifc.cycles = CYC_BIT;
      end
      COL_BRANCH: begin
        ifc.iclass = CLS_BRANCH;
        ifc.mode   = MODE_REL;
        ifc.length = LEN_TWO;
        ifc.cycles = CYC_BRANCH;
      end
      COL_RMW_DIR, COL_RMW_ACC, COL_RMW_IDX, COL_RMW_IX1, COL_RMW_IX: begin
        ifc.iclass  = CLS_RMW;
        ifc.defined = ROWS_RMW[row];
        case (col)
          COL_RMW_DIR: begin
            ifc.mode   = MODE_DIR;
            ifc.length = LEN_TWO;
            ifc.cycles = CYC_RMW_DIR;
          end
          COL_RMW_IX1: begin
            ifc.mode   = MODE_IX1;
            ifc.length = LEN_TWO;
            ifc.cycles = CYC_RMW_IX1;
          end
          COL_RMW_IX: begin
            ifc.mode   = MODE_IX;
            ifc.cycles = CYC_RMW_IX;
          end
          default: begin
            ifc.cycles = CYC_RMW_INH;
          end
        endcase
        if (ifc.opcode == OPC_MULTIPLY) begin
          ifc.iclass  = CLS_CTL;
          ifc.defined = 1'b1;
          ifc.cycles  = CYC_MULTIPLY;
        end
      end
      COL_CTL_LO, COL_CTL_HI: begin
        ifc.defined = (col == COL_CTL_LO) ? ROWS_CTL_LO[row] : ROWS_CTL_HI[row];
        case (ifc.opcode)
          OPC_INT_RETURN: ifc.cycles = CYC_INT_RET;
          OPC_SUB_RETURN: ifc.cycles = CYC_SUB_RET;
          OPC_SOFT_TRAP:  ifc.cycles = CYC_SOFT_TRAP;
          default:        ifc.cycles = CYC_INH;
        endcase
      end
      default: begin
        ifc.iclass = CLS_REGMEM;
        case (col)
          COL_IMM: begin
            ifc.mode    = MODE_IMM;
            ifc.length  = LEN_TWO;
            ifc.cycles  = CYC_IMM;
            ifc.defined = ROWS_IMM[row];
          end
          COL_DIR: begin
            ifc.mode   = MODE_DIR;
            ifc.length = LEN_TWO;
            ifc.cycles = CYC_DIR;
          end
          COL_EXT: begin
            ifc.mode   = MODE_EXT;
            ifc.length = LEN_THREE;
            ifc.cycles = CYC_EXT;
          end
          COL_IX2: begin
            ifc.mode   = MODE_IX2;
            ifc.length = LEN_THREE;
            ifc.cycles = CYC_IX2;
          end
          COL_IX1: begin
            ifc.mode   = MODE_IX1;
            ifc.length = LEN_TWO;
            ifc.cycles = CYC_IX1;
          end
          default: begin
            ifc.mode   = MODE_IX;
            ifc.cycles = CYC_IX;
          end
        endcase
      end
    endcase
    // Blank map positions run as a plain one-byte no-operation
    if (!ifc.defined) begin
      ifc.iclass = CLS_CTL;
      ifc.mode   = MODE_INH;
      ifc.length = LEN_ONE;
      ifc.cycles = CYC_INH;
    end
  end

endmodule // cod_opcode_lut
`default_nettype wire

// ===== tb/cod_prog_mem.sv
// Program memory model answering operand fetches.
// Assumes clk_sys domain; byte k of the run is k*0x11, k from 1.
`timescale 1ns/1ns
`default_nettype none
module cod_prog_mem (
  input  wire logic       clk_sys,
  input  wire logic       fetch_req,
  output logic            operand_valid,
  output logic [7:0]      operand_byte
);
  logic [7:0] k = 8'h01;
  initial operand_valid = 1'b0;
  initial operand_byte = 8'hFF;
  // Idle bus toggles so stale bytes are never mistaken for data
  always @(negedge clk_sys) begin
    operand_valid <= fetch_req;
    operand_byte  <= fetch_req ? k * 8'h11 : ~operand_byte;
  end
  always @(posedge clk_sys) begin
    if (fetch_req && operand_valid) begin
      k <= k + 8'h01;
    end
  end
endmodule // cod_prog_mem
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the opcode decode top.
// Assumes cod_prog_mem answers operand fetches at once.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import cod_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        op_valid = 1'b0;
  logic [7:0]  op_byte = 8'h00;
  logic [7:0]  index_val = 8'hA5;
  logic [4:0]  ccr_in = 5'h1F;
  logic        irq_pin = 1'b0;
  logic        operand_valid, op_ready, fetch_req, busy, dec_bit_when_set;
  logic        dec_undefined, acc_we, ccr_we, clk_halt, insn_done;
  logic [7:0]  operand_byte, acc_value;
  logic [1:0]  dec_length;
  logic [3:0]  dec_row;
  logic [2:0]  dec_bit_num;
  logic [4:0]  ccr_out;
  logic [15:0] operand_word, e, m;
  cod_class_t  dec_class;
  cod_mode_t   dec_mode;
  int          err_total = 0;
  int          samples_checked = 0;
  int          n;
  int          nb = 1;
  logic [15:0] tbl [11] = '{
    {8'hA6, CLS_REGMEM, MODE_IMM, 2'h2}, {8'hB6, CLS_REGMEM, MODE_DIR, 2'h2},
    {8'hC6, CLS_REGMEM, MODE_EXT, 2'h3}, {8'hD6, CLS_REGMEM, MODE_IX2, 2'h3},
    {8'hE6, CLS_REGMEM, MODE_IX1, 2'h2}, {8'hF6, CLS_REGMEM, MODE_IX, 2'h1},
    {8'h05, CLS_BITMAN, MODE_DIR, 2'h3}, {8'h14, CLS_BITMAN, MODE_DIR, 2'h2},
    {8'h27, CLS_BRANCH, MODE_REL, 2'h2}, {8'h6C, CLS_RMW, MODE_IX1, 2'h2},
    {8'h97, CLS_CTL, MODE_INH, 2'h1}};

  cod_decode_top i_cod_decode_top (.clk_sys, .rst_n, .op_valid, .op_byte, .operand_valid,
    .operand_byte, .index_val, .ccr_in, .irq_pin, .op_ready, .fetch_req, .busy, .dec_class,
    .dec_mode, .dec_length, .dec_row, .dec_bit_num, .dec_bit_when_set, .dec_undefined,
    .operand_word, .acc_we, .acc_value, .ccr_we, .ccr_out, .clk_halt, .insn_done);
  cod_prog_mem i_cod_prog_mem (.clk_sys, .fetch_req, .operand_valid, .operand_byte);

  always #5 clk_sys = ~clk_sys;

  // ==========================================================
  // Tasks
  // ==========================================================
  function automatic logic [7:0] bv(input int k);
    return k[7:0] * 8'h11;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Called on a falling edge; n counts falling edges to insn_done
  task automatic wait_done;
    n = 1;
    while (insn_done !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  task automatic run(input logic [7:0] op);
    op_valid = 1'b1;
    op_byte = op;
    @(negedge clk_sys);
    op_valid = 1'b0;
    wait_done;
  endtask
  task automatic final_report;
    if (err_total == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // Tests
  // ==========================================================
  initial begin
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    chk(op_ready, 16'h1);
    run(OPC_IDX_TO_ACC);
    chk(n[15:0], 16'h2);
    chk({acc_we, ccr_we, acc_value, ccr_out}, {1'b1, 1'b1, 8'hA5, 5'h1F});
    chk({op_ready, busy}, 2'h2);
    foreach (tbl[i]) begin
      run(tbl[i][15:8]);
      chk(dec_class, tbl[i][7:5]);
      chk(dec_mode, tbl[i][4:2]);
      chk(dec_length, tbl[i][1:0]);
      chk({dec_row, dec_undefined}, {tbl[i][11:8], 1'b0});
      if (tbl[i][7:5] == CLS_BITMAN) chk({dec_bit_num, dec_bit_when_set}, {tbl[i][11:9], ~tbl[i][8]});
      e = (tbl[i][1:0] == 2'h3) ? {bv(nb), bv(nb + 1)} : {8'h00, bv(nb)};
      m = (tbl[i][1:0] == 2'h3) ? 16'hFFFF : 16'h00FF;
      if (tbl[i][1:0] > 2'h1) chk(operand_word & m, e);
      nb = nb + tbl[i][1:0] - 1;
    end
    run(OPC_MULTIPLY);
    chk(n[15:0], 16'hB);
    run(OPC_CARRY_CLR);
    chk(ccr_out, 5'h1E);
    run(8'h31);
    chk({n[3:0], dec_undefined}, {4'h2, 1'b1});
    for (int j = 0; j < 2; j++) begin
      ccr_in = 5'h1F;
      run(j == 0 ? OPC_WAIT : OPC_STOP);
      chk({clk_halt, busy, op_ready, ccr_out}, {1'b1, 1'b1, 1'b0, 5'h17});
      irq_pin = 1'b1;
      wait_done;
      chk({insn_done, clk_halt}, {1'b1, 1'b0});
      irq_pin = 1'b0;
      // Let the synchronised interrupt fall before the next halt
      repeat (5) @(negedge clk_sys);
    end
    final_report;
  end

  initial begin
    #20000;
    err_total++;
    final_report;
  end
endmodule // tb_top
`default_nettype wire
